// File: design/ccbi_device.sv
`timescale 1ns/1ps
// Device end: frame receiver, control interpreter and acyclic server.
module ccbi_device
  import ccbi_pkg::*;
(
  ccbi_if.dev                              link,
  input  logic [CCBI_FAULT_W-1:0]          fault,
  input  logic [7:0]                       cmd_rdata,
  output logic [CCBI_FN_COUNT-1:0]         func_pulse,
  output logic                             cont_clr_max,
  output logic                             cont_clr_min,
  output logic                             hold_max,
  output logic                             hold_min,
  output logic [CCBI_NUM_LIMITS-1:0][31:0] thr_level,
  output logic [8*CCBI_CWR_BYTES-1:0]      cwr_field,
  output logic [8*CCBI_CRD_BYTES-1:0]      crd_field,
  output logic                             frame_done,
  output logic                             cmd_valid,
  output logic                             cmd_wr,
  output logic [7:0]                       cmd_slot,
  output logic [7:0]                       cmd_index,
  output logic [7:0]                       cmd_wdata
);
  typedef struct packed {
    ccbi_rx_t                              rx;
    logic [CCBI_FIDX_W-1:0]                idx;
    logic [CCBI_FRAME_BYTES-1:0][7:0]      fbytes;
    logic [7:0]                            mask1;
    logic [7:0]                            mask2;
    logic [7:0]                            prev1;
    logic [7:0]                            prev2;
    logic [7:0]                            ack1;
    logic [7:0]                            ack2;
    logic                                  frame_ack;
    logic [CCBI_FN_COUNT-1:0]              pend;
    logic [CCBI_FN_COUNT-1:0]              fire;
    logic                                  cclr_max;
    logic                                  cclr_min;
    logic                                  hold_max;
    logic                                  hold_min;
    logic [CCBI_NUM_LIMITS-1:0][31:0]      thr;
    logic [8*CCBI_CWR_BYTES-1:0]           cwr;
    logic [8*CCBI_CRD_BYTES-1:0]           crd;
    logic [7:0]                            diag5;
    logic                                  rr;
    logic [CCBI_NUM_MST-1:0]               ac_done;
    logic [7:0]                            ac_rdata;
    logic                                  ac_err;
    logic                                  cmd_valid;
    logic                                  cmd_wr;
    logic [7:0]                            cmd_slot;
    logic [7:0]                            cmd_index;
    logic [7:0]                            cmd_wdata;
    logic                                  fwd_g;
  } ccbi_dev_st_t;

  ccbi_dev_st_t             q;
  ccbi_dev_st_t             d;
  logic [7:0]               c1;
  logic [7:0]               c2;
  logic [7:0]               m1;
  logic [7:0]               m2;
  logic [7:0]               e1;
  logic [7:0]               e2;
  logic [CCBI_FN_COUNT-1:0] n;
  logic                     gnt;
  logic                     g;
  logic [7:0]               slot;
  logic [7:0]               index;

  always_comb begin
    d = q;
    d.frame_ack = 1'b0;
    d.ac_done   = '0;
    d.cmd_valid = 1'b0;
    n     = '0;
    slot  = 8'h00;
    index = 8'h00;
    c1 = q.fbytes[CCBI_OFS_CTRL1];
    c2 = q.fbytes[CCBI_OFS_CTRL2] & CCBI_C2_USED;
    m1 = c1 & q.mask1;
    m2 = c2 & q.mask2;
    e1 = m1 & ~q.prev1;
    e2 = m2 & ~q.prev2;

    unique case (q.rx)
      CCBI_RX_IDLE: begin
        if (link.out_valid && link.out_sof) begin
          d.fbytes[CCBI_OFS_CTRL1] = link.out_byte;
          d.idx = CCBI_FIDX_W'(1);
          d.rx  = CCBI_RX_FRAME;
        end
      end
      CCBI_RX_FRAME: begin
        if (link.out_valid && link.out_sof) begin
          d.fbytes[CCBI_OFS_CTRL1] = link.out_byte;
          d.idx = CCBI_FIDX_W'(1);
        end else if (link.out_valid) begin
          d.fbytes[q.idx] = link.out_byte;
          d.idx = q.idx + 1'b1;
          if (q.idx == CCBI_FIDX_LAST) begin
            d.rx = CCBI_RX_COMMIT;
          end
        end
      end
      CCBI_RX_COMMIT: begin
        d.ack1 = q.fbytes[CCBI_OFS_CTRL1];
        d.ack2 = q.fbytes[CCBI_OFS_CTRL2];
        d.frame_ack = 1'b1;
        d.prev1 = m1;
        d.prev2 = m2;
        d.cclr_max = m1[C1_CCLR_MAX];
        d.cclr_min = m1[C1_CCLR_MIN];
        d.hold_max = m1[C1_HOLD_MAX];
        d.hold_min = m1[C1_HOLD_MIN];
        n[CCBI_FN_ZERO]    = e1[C1_ZERO] | e2[C2_ZERO];
        n[CCBI_FN_TARE]    = e1[C1_TARE] | e2[C2_TARE];
        n[CCBI_FN_OCLR_MAX] = e1[C1_OCLR_MAX] & ~m1[C1_CCLR_MAX];
        n[CCBI_FN_OCLR_MIN] = e1[C1_OCLR_MIN] & ~m1[C1_CCLR_MIN];
        n[CCBI_FN_HYST]    = m2[C2_HYST];
        n[CCBI_FN_AUTOCAL] = e2[C2_AUTOCAL];
        n[CCBI_FN_SCALE]   = e2[C2_SCALE];
        for (int i = 0; i < CCBI_NUM_LIMITS; i++) begin
          for (int j = 0; j < CCBI_THR_BYTES; j++) begin
            d.thr[i][8*(CCBI_THR_BYTES-1-j) +: 8] =
              q.fbytes[ccbi_thr_ofs(i, j)];
          end
        end
        for (int j = 0; j < CCBI_CWR_BYTES; j++) begin
          d.cwr[8*(CCBI_CWR_BYTES-1-j) +: 8] = q.fbytes[CCBI_OFS_CWR+j];
        end
        for (int j = 0; j < CCBI_CRD_BYTES; j++) begin
          d.crd[8*(CCBI_CRD_BYTES-1-j) +: 8] = q.fbytes[CCBI_OFS_CRD+j];
        end
        d.rx = CCBI_RX_IDLE;
      end
    endcase

    // zero, tare, one-off peak clears, hysteresis, autocal, scaling
    // One function fires per cycle; a fresh request re-sets its slot.
    d.fire = ccbi_lowest(q.pend);
    d.pend = (q.pend & ~d.fire) | n;

    d.diag5 = {CCBI_DIAG_RSV, fault};

    // A forwarded command is answered by the user in the same cycle that cmd_valid is high.
    if (q.cmd_valid) begin
      d.ac_done[q.fwd_g] = 1'b1;
      d.ac_rdata = cmd_rdata;
      d.ac_err = 1'b0;
    end

    // acyclic waits for idle
    // The done cycle is skipped so a held request is not served twice.
    gnt = (q.rx == CCBI_RX_IDLE) && !link.out_valid && !q.cmd_valid &&
          (q.ac_done == '0) && (link.ac_req != '0);
    g = link.ac_req[1] && (!link.ac_req[0] || q.rr);
    if (gnt) begin
      slot  = link.ac_addr[g][15:8];
      index = link.ac_addr[g][7:0];
      d.rr = ~g;
      d.ac_err = 1'b0;
      d.ac_rdata = 8'h00;
      if (slot == CCBI_AC_SLOT_CFG && index == CCBI_AC_IDX_MASK1) begin
        if (link.ac_wr[g]) begin
          d.mask1 = link.ac_wdata[g];
        end
        d.ac_rdata = q.mask1;
        d.ac_done[g] = 1'b1;
      end else if (slot == CCBI_AC_SLOT_CFG &&
                   index == CCBI_AC_IDX_MASK2) begin
        if (link.ac_wr[g]) begin
          d.mask2 = link.ac_wdata[g];
        end
        d.ac_rdata = q.mask2;
        d.ac_done[g] = 1'b1;
      end else if (slot == CCBI_AC_SLOT_CFG &&
                   index == CCBI_AC_IDX_DIAG) begin
        d.ac_err = link.ac_wr[g];
        d.ac_rdata = q.diag5;
        d.ac_done[g] = 1'b1;
      end else begin
        d.cmd_valid = 1'b1;
        d.cmd_wr    = link.ac_wr[g];
        d.cmd_slot  = slot;
        d.cmd_index = index;
        d.cmd_wdata = link.ac_wdata[g];
        d.fwd_g     = g;
      end
    end
  end

  always_ff @(posedge link.clk or negedge link.reset_n) begin
    if (!link.reset_n) begin
      q <= '0;
      q.rx <= CCBI_RX_IDLE;
      q.mask1 <= CCBI_MASK_RST;
      q.mask2 <= CCBI_MASK_RST;
    end else begin
      q <= d;
    end
  end

  assign link.diag = {CCBI_DIAG_B1, CCBI_DIAG_B2, CCBI_DIAG_B3,
                      CCBI_DIAG_B4, q.diag5};
  assign link.ack1      = q.ack1;
  assign link.ack2      = q.ack2;
  assign link.frame_ack = q.frame_ack;
  assign link.ac_done   = q.ac_done;
  assign link.ac_rdata  = q.ac_rdata;
  assign link.ac_err    = q.ac_err;
  assign func_pulse     = q.fire;
  assign cont_clr_max   = q.cclr_max;
  assign cont_clr_min   = q.cclr_min;
  assign hold_max       = q.hold_max;
  assign hold_min       = q.hold_min;
  assign thr_level      = q.thr;
  assign cwr_field      = q.cwr;
  assign crd_field      = q.crd;
  assign frame_done     = q.frame_ack;
  assign cmd_valid      = q.cmd_valid;
  assign cmd_wr         = q.cmd_wr;
  assign cmd_slot       = q.cmd_slot;
  assign cmd_index      = q.cmd_index;
  assign cmd_wdata      = q.cmd_wdata;
endmodule

// File: include/ccbi_pkg.sv
// Constants and types shared by both ends of the control byte link.
// Overview of operation
// - Master sends first control byte for zero/tare/peaks.
// - First byte bit map: zero, tare, peak controls.
// - First byte order: zero, tare, then peaks.
// - Continuous peak clear beats one-off clear.
// - Second byte bit map: autocal, zero, tare, hysteresis, scaling.
// - Second byte order: zero, tare, hysteresis, autocal.
// - Master never sends scaling with other bits.
// - Per byte enable masks gate every function.
// - Both masks enable everything after reset.
// - Received control bytes are echoed back.
// - One-off functions start only on rising bits, except hysteresis, which fires on every frame with its bit set.
// - Four limit thresholds of four bytes each.
// - Six byte container write, two byte read.
// - Diagnosis is five bytes: 5, 129, 0, 0.
// - Diagnosis byte five fault bits, top two zero.
// - Fault bits follow the fault condition exactly.
// - Acyclic access yields to cyclic traffic.
// - Two masters may access acyclic parameters concurrently.
// - Acyclic parameters addressed by slot and index.
// - Multi-byte values travel most significant byte first.
// - Each control byte echo uses one byte.
package ccbi_pkg;
  localparam int CCBI_NUM_LIMITS  = 4;
  localparam int CCBI_THR_BYTES   = 4;
  localparam int CCBI_CWR_BYTES   = 6;
  localparam int CCBI_CRD_BYTES   = 2;
  localparam int CCBI_OFS_CTRL1   = 0;
  localparam int CCBI_OFS_CTRL2   = 1;
  localparam int CCBI_OFS_THR     = 2;
  localparam int CCBI_OFS_CWR     = CCBI_OFS_THR
                                    + CCBI_NUM_LIMITS * CCBI_THR_BYTES;
  localparam int CCBI_OFS_CRD     = CCBI_OFS_CWR + CCBI_CWR_BYTES;
  localparam int CCBI_FRAME_BYTES = CCBI_OFS_CRD + CCBI_CRD_BYTES;
  localparam int CCBI_FIDX_W      = $clog2(CCBI_FRAME_BYTES);
  localparam logic [CCBI_FIDX_W-1:0] CCBI_FIDX_LAST =
    CCBI_FIDX_W'(CCBI_FRAME_BYTES - 1);

  localparam int C1_ZERO     = 0;
  localparam int C1_TARE     = 1;
  localparam int C1_CCLR_MAX = 2;
  localparam int C1_CCLR_MIN = 3;
  localparam int C1_OCLR_MAX = 4;
  localparam int C1_OCLR_MIN = 5;
  localparam int C1_HOLD_MAX = 6;
  localparam int C1_HOLD_MIN = 7;
  localparam int C2_AUTOCAL  = 0;
  localparam int C2_ZERO     = 1;
  localparam int C2_TARE     = 2;
  localparam int C2_HYST     = 3;
  localparam int C2_SCALE    = 7;
  localparam logic [7:0] CCBI_C2_USED  = 8'h8F;
  localparam logic [7:0] CCBI_C2_SCALE = 8'h80;
  localparam logic [7:0] CCBI_MASK_RST = 8'hFF;

  // Function slots; a lower index is executed first.
  localparam int CCBI_FN_ZERO     = 0;
  localparam int CCBI_FN_TARE     = 1;
  localparam int CCBI_FN_OCLR_MAX = 2;
  localparam int CCBI_FN_OCLR_MIN = 3;
  localparam int CCBI_FN_HYST     = 4;
  localparam int CCBI_FN_AUTOCAL  = 5;
  localparam int CCBI_FN_SCALE    = 6;
  localparam int CCBI_FN_COUNT    = 7;

  localparam int CCBI_FAULT_W = 6;
  localparam int CCBI_DIAG_W  = 40;
  localparam logic [7:0] CCBI_DIAG_B1 = 8'h05;
  localparam logic [7:0] CCBI_DIAG_B2 = 8'h81;
  localparam logic [7:0] CCBI_DIAG_B3 = 8'h00;
  localparam logic [7:0] CCBI_DIAG_B4 = 8'h00;
  localparam logic [1:0] CCBI_DIAG_RSV = 2'h0;

  localparam int CCBI_NUM_MST = 2;
  localparam logic [7:0] CCBI_AC_SLOT_CFG  = 8'h00;
  localparam logic [7:0] CCBI_AC_IDX_MASK1 = 8'h01;
  localparam logic [7:0] CCBI_AC_IDX_MASK2 = 8'h02;
  localparam logic [7:0] CCBI_AC_IDX_DIAG  = 8'h03;

  typedef enum logic [1:0] {CCBI_RX_IDLE, CCBI_RX_FRAME, CCBI_RX_COMMIT}
    ccbi_rx_t;
  typedef enum logic {CCBI_TX_IDLE, CCBI_TX_SEND} ccbi_tx_t;

  function automatic logic [CCBI_FN_COUNT-1:0] ccbi_lowest(
    input logic [CCBI_FN_COUNT-1:0] v);
    return v & (~v + 1'b1);
  endfunction

  function automatic int ccbi_thr_ofs(input int i, input int j);
    return CCBI_OFS_THR + CCBI_THR_BYTES * i + j;
  endfunction
endpackage

// File: include/ccbi_if.sv
`timescale 1ns/1ps
// Link between the cyclic master and the interpreting device.
interface ccbi_if
  import ccbi_pkg::*;
(
  input logic clk,
  input logic reset_n
);
  logic [7:0]                        out_byte;
  logic                              out_valid;
  logic                              out_sof;
  logic [7:0]                        ack1;
  logic [7:0]                        ack2;
  logic                              frame_ack;
  logic [CCBI_DIAG_W-1:0]            diag;
  logic [CCBI_NUM_MST-1:0]           ac_req;
  logic [CCBI_NUM_MST-1:0]           ac_wr;
  logic [CCBI_NUM_MST-1:0][15:0]     ac_addr;
  logic [CCBI_NUM_MST-1:0][7:0]      ac_wdata;
  logic [CCBI_NUM_MST-1:0]           ac_done;
  logic [7:0]                        ac_rdata;
  logic                              ac_err;

  modport dev (input clk, reset_n, out_byte, out_valid, out_sof,
               ac_req, ac_wr, ac_addr, ac_wdata,
               output ack1, ack2, frame_ack, diag, ac_done, ac_rdata,
               ac_err);
  modport mst (input clk, reset_n, ack1, ack2, frame_ack, diag,
               ac_done, ac_rdata, ac_err,
               output out_byte, out_valid, out_sof,
               ac_req, ac_wr, ac_addr, ac_wdata);
endinterface

// File: design/ccbi_master.sv
`timescale 1ns/1ps
// Master end: frame serializer and acyclic request holder.
module ccbi_master
  import ccbi_pkg::*;
(
  ccbi_if.mst                              link,
  input  logic                             send,
  input  logic [7:0]                       ctrl1,
  input  logic [7:0]                       ctrl2,
  input  logic [CCBI_NUM_LIMITS-1:0][31:0] thr_level,
  input  logic [8*CCBI_CWR_BYTES-1:0]      cwr_field,
  input  logic [8*CCBI_CRD_BYTES-1:0]      crd_field,
  input  logic [CCBI_NUM_MST-1:0]          ac_start,
  input  logic [CCBI_NUM_MST-1:0]          ac_wr,
  input  logic [CCBI_NUM_MST-1:0][15:0]    ac_addr,
  input  logic [CCBI_NUM_MST-1:0][7:0]     ac_wdata,
  output logic                             busy,
  output logic                             frame_done,
  output logic [7:0]                       ack1,
  output logic [7:0]                       ack2,
  output logic [CCBI_DIAG_W-1:0]           diag,
  output logic [CCBI_NUM_MST-1:0]          ac_busy,
  output logic [CCBI_NUM_MST-1:0]          ac_done,
  output logic [7:0]                       ac_rdata,
  output logic                             ac_err
);
  typedef struct packed {
    ccbi_tx_t                              tx;
    logic                                  busy;
    logic [CCBI_FIDX_W-1:0]                idx;
    logic [CCBI_FRAME_BYTES-1:0][7:0]      fbytes;
    logic [7:0]                            out_byte;
    logic                                  out_valid;
    logic                                  out_sof;
    logic                                  frame_done;
    logic [7:0]                            ack1;
    logic [7:0]                            ack2;
    logic [CCBI_DIAG_W-1:0]                diag;
    logic [CCBI_NUM_MST-1:0]               req;
    logic [CCBI_NUM_MST-1:0]               wr;
    logic [CCBI_NUM_MST-1:0][15:0]         addr;
    logic [CCBI_NUM_MST-1:0][7:0]          wdata;
    logic [CCBI_NUM_MST-1:0]               done;
    logic [7:0]                            rdata;
    logic                                  err;
  } ccbi_mst_st_t;

  ccbi_mst_st_t q;
  ccbi_mst_st_t d;
  logic [7:0]   c1;
  logic [7:0]   c2;

  always_comb begin
    d = q;
    d.out_valid  = 1'b0;
    d.out_sof    = 1'b0;
    d.frame_done = 1'b0;
    d.done       = '0;
    d.diag       = link.diag;
    c1 = ctrl1;
    c2 = ctrl2;
    if (ctrl2[C2_SCALE]) begin
      c1 = 8'h00;
      c2 = CCBI_C2_SCALE;
    end
    if (link.frame_ack) begin
      d.ack1 = link.ack1;
      d.ack2 = link.ack2;
      d.frame_done = 1'b1;
    end
    unique case (q.tx)
      CCBI_TX_IDLE: begin
        if (send) begin
          d.fbytes[CCBI_OFS_CTRL1] = c1;
          d.fbytes[CCBI_OFS_CTRL2] = c2;
          for (int i = 0; i < CCBI_NUM_LIMITS; i++) begin
            for (int j = 0; j < CCBI_THR_BYTES; j++) begin
              d.fbytes[ccbi_thr_ofs(i, j)] =
                thr_level[i][8*(CCBI_THR_BYTES-1-j) +: 8];
            end
          end
          for (int j = 0; j < CCBI_CWR_BYTES; j++) begin
            d.fbytes[CCBI_OFS_CWR+j] =
              cwr_field[8*(CCBI_CWR_BYTES-1-j) +: 8];
          end
          for (int j = 0; j < CCBI_CRD_BYTES; j++) begin
            d.fbytes[CCBI_OFS_CRD+j] =
              crd_field[8*(CCBI_CRD_BYTES-1-j) +: 8];
          end
          d.idx  = '0;
          d.busy = 1'b1;
          d.tx   = CCBI_TX_SEND;
        end
      end
      CCBI_TX_SEND: begin
        d.out_byte  = q.fbytes[q.idx];
        d.out_valid = 1'b1;
        d.out_sof   = (q.idx == '0);
        d.idx       = q.idx + 1'b1;
        if (q.idx == CCBI_FIDX_LAST) begin
          d.busy = 1'b0;
          d.tx   = CCBI_TX_IDLE;
        end
      end
    endcase
    for (int k = 0; k < CCBI_NUM_MST; k++) begin
      if (q.req[k] && link.ac_done[k]) begin
        d.req[k]  = 1'b0;
        d.done[k] = 1'b1;
        d.rdata   = link.ac_rdata;
        d.err     = link.ac_err;
      end else if (!q.req[k] && ac_start[k]) begin
        d.req[k]   = 1'b1;
        d.wr[k]    = ac_wr[k];
        d.addr[k]  = ac_addr[k];
        d.wdata[k] = ac_wdata[k];
      end
    end
  end

  always_ff @(posedge link.clk or negedge link.reset_n) begin
    if (!link.reset_n) begin
      q <= '0;
      q.tx <= CCBI_TX_IDLE;
    end else begin
      q <= d;
    end
  end

  assign link.out_byte  = q.out_byte;
  assign link.out_valid = q.out_valid;
  assign link.out_sof   = q.out_sof;
  assign link.ac_req    = q.req;
  assign link.ac_wr     = q.wr;
  assign link.ac_addr   = q.addr;
  assign link.ac_wdata  = q.wdata;
  assign busy           = q.busy;
  assign frame_done     = q.frame_done;
  assign ack1           = q.ack1;
  assign ack2           = q.ack2;
  assign diag           = q.diag;
  assign ac_busy        = q.req;
  assign ac_done        = q.done;
  assign ac_rdata       = q.rdata;
  assign ac_err         = q.err;
endmodule

// File: tb/ccbi_asserts.sv
// Checker for the frame link and the acyclic handshakes.
`timescale 1ns/1ps
module ccbi_asserts
  import ccbi_pkg::*;
(
  input logic                    clk,
  input logic                    reset_n,
  input logic                    out_valid,
  input logic                    out_sof,
  input logic [7:0]              ack1,
  input logic [7:0]              ack2,
  input logic                    frame_ack,
  input logic [CCBI_DIAG_W-1:0]  diag,
  input logic [CCBI_NUM_MST-1:0] ac_req,
  input logic [CCBI_NUM_MST-1:0] ac_done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_last_byte;
    out_valid ##1 !out_valid;
  endsequence
  sequence s_body;
    (out_valid && !out_sof) [*8];
  endsequence

  property p_commit;
    s_last_byte |=> frame_ack;
  endproperty
  a_commit: assert property (p_commit)
    else $error("frame commit missing after last byte");
  property p_ack_cause;
    frame_ack |-> $past(out_valid, 2) && !$past(out_valid);
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("frame ack without a finished frame");
  property p_ack_hold;
    !frame_ack |-> $stable(ack1) && $stable(ack2);
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("echo bytes changed outside a commit");
  property p_diag;
    diag[39:6] == {CCBI_DIAG_B1, CCBI_DIAG_B2, CCBI_DIAG_B3,
                   CCBI_DIAG_B4, CCBI_DIAG_RSV};
  endproperty
  a_diag: assert property (p_diag)
    else $error("fixed diagnosis bytes wrong");
  property p_sof;
    $rose(out_valid) |-> out_sof;
  endproperty
  a_sof: assert property (p_sof)
    else $error("frame did not open with start byte");
  property p_frame;
    out_sof |-> out_valid ##1 s_body;
  endproperty
  a_frame: assert property (p_frame)
    else $error("frame bytes not consecutive");
  property p_done_drop;
    ac_done != 0 |=> (ac_req & $past(ac_done)) == 0;
  endproperty
  a_done_drop: assert property (p_done_drop)
    else $error("request held after its answer");
  property p_defer;
    out_valid && $past(out_valid) && !$past(out_sof) |-> ac_done == 0;
  endproperty
  a_defer: assert property (p_defer)
    else $error("acyclic answer inside a frame");
  property p_done_pulse;
    (ac_done & $past(ac_done)) == 0;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("acyclic answer longer than one cycle");
endmodule

// File: tb/tb.sv
// Self-checking bench for both ends of the control byte link.
`timescale 1ns/1ps
module tb
  import ccbi_pkg::*;
;
  logic clk, reset_n, send, busy, m_done, d_done, ac_err, cv, cw;
  logic ccmax, ccmin, hmax, hmin;
  logic [7:0] c1, c2, m_ack1, m_ack2, ac_rdata, cs, ci, cd, mk1, mk2, p1, p2;
  logic [3:0][31:0] thr, d_thr;
  logic [47:0] cwr, d_cwr;
  logic [15:0] crd, d_crd;
  logic [1:0] ac_start, ac_wr, ac_busy, ac_done;
  logic [1:0][15:0] ac_addr;
  logic [1:0][7:0] ac_wdata;
  logic [39:0] m_diag;
  logic [5:0] fault;
  logic [6:0] fp;
  logic [24:0] cmd_q;
  logic [7:0] wire_q[$];
  logic [6:0] pul_q[$];
  int mismatches = 0;
  int n_tests = 0;
  int cyc = 0;

  ccbi_if ccbi_if_i (.clk(clk), .reset_n(reset_n));
  ccbi_master ccbi_master_i (.link(ccbi_if_i), .send(send), .ctrl1(c1),
    .ctrl2(c2), .thr_level(thr), .cwr_field(cwr), .crd_field(crd),
    .ac_start(ac_start), .ac_wr(ac_wr), .ac_addr(ac_addr),
    .ac_wdata(ac_wdata), .busy(busy), .frame_done(m_done), .ack1(m_ack1),
    .ack2(m_ack2), .diag(m_diag), .ac_busy(ac_busy), .ac_done(ac_done),
    .ac_rdata(ac_rdata), .ac_err(ac_err));
  ccbi_device ccbi_device_i (.link(ccbi_if_i), .fault(fault),
    .cmd_rdata(ci ^ 8'h5A), .func_pulse(fp), .cont_clr_max(ccmax),
    .cont_clr_min(ccmin), .hold_max(hmax), .hold_min(hmin),
    .thr_level(d_thr), .cwr_field(d_cwr), .crd_field(d_crd),
    .frame_done(d_done), .cmd_valid(cv), .cmd_wr(cw), .cmd_slot(cs),
    .cmd_index(ci), .cmd_wdata(cd));
  ccbi_asserts ccbi_asserts_i (.clk(clk), .reset_n(reset_n),
    .out_valid(ccbi_if_i.out_valid), .out_sof(ccbi_if_i.out_sof),
    .ack1(ccbi_if_i.ack1), .ack2(ccbi_if_i.ack2),
    .frame_ack(ccbi_if_i.frame_ack), .diag(ccbi_if_i.diag),
    .ac_req(ccbi_if_i.ac_req), .ac_done(ccbi_if_i.ac_done));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [127:0] got, exp, input string what);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (ccbi_if_i.out_valid === 1'b1) wire_q.push_back(ccbi_if_i.out_byte);
    if (fp !== 7'h0) pul_q.push_back(fp);
    if (cv === 1'b1) cmd_q <= {cw, cs, ci, cd};
    if (cyc > 20000) begin
      mismatches++;
      close_out();
    end
  end

  task automatic frame(input logic [7:0] a, b);
    logic [7:0] e1, e2, m1, m2, r1, r2;
    logic [7:0] wb[26];
    logic [6:0] ef;
    int k, i;
    wire_q.delete();
    pul_q.delete();
    @(posedge clk);
    send <= 1'b1;
    c1 <= a;
    c2 <= b;
    for (k = 0; k < 4; k++) thr[k] <= $urandom;
    cwr <= {$urandom, 16'($urandom)};
    crd <= 16'($urandom);
    @(posedge clk);
    send <= 1'b0;
    @(negedge clk);
    chk(busy, 1'b1, "master not busy");
    for (k = 0; k < 60 && d_done !== 1'b1; k++) @(negedge clk);
    chk(d_done, 1, "frame not committed");
    @(negedge clk);
    chk({m_done, busy}, 2'b10, "master frame end");
    repeat (12) @(negedge clk);
    // Scaling travels alone, so the master strips the other bits.
    e1 = b[7] ? 8'h00 : a;
    e2 = b[7] ? 8'h80 : b;
    wb[0] = e1;
    wb[1] = e2;
    for (k = 0; k < 16; k++) wb[2 + k] = thr[k / 4][31 - 8 * (k % 4) -: 8];
    for (k = 0; k < 6; k++) wb[18 + k] = cwr[47 - 8 * k -: 8];
    wb[24] = crd[15:8];
    wb[25] = crd[7:0];
    chk(wire_q.size(), 26, "frame length");
    for (k = 0; k < 26; k++) chk(wire_q[k], wb[k], "wire byte");
    m1 = e1 & mk1;
    m2 = e2 & mk2;
    r1 = m1 & ~p1;
    r2 = m2 & ~p2;
    p1 = m1;
    p2 = m2;
    ef = {r2[7], r2[0], m2[3], r1[5] & ~m1[3], r1[4] & ~m1[2],
          r1[1] | r2[2], r1[0] | r2[1]};
    i = 0;
    for (k = 0; k < 7; k++)
      if (ef[k]) begin
        chk(pul_q[i], 7'h1 << k, "pulse order");
        i++;
      end
    chk(pul_q.size(), i, "pulse count");
    chk({ccmax, ccmin, hmax, hmin}, {m1[2], m1[3], m1[6], m1[7]}, "lvl");
    chk({m_ack1, m_ack2}, {e1, e2}, "echo");
    chk(d_thr, thr, "thresholds");
    chk({d_cwr, d_crd}, {cwr, crd}, "containers");
  endtask

  task automatic ac(input int m, input logic w, input logic [15:0] ad,
                    input logic [7:0] wd, ed, input logic ee);
    int k;
    @(posedge clk);
    ac_start[m] <= 1'b1;
    ac_wr[m] <= w;
    ac_addr[m] <= ad;
    ac_wdata[m] <= wd;
    @(posedge clk);
    ac_start[m] <= 1'b0;
    @(negedge clk);
    chk(ac_busy[m], 1'b1, "request not held");
    for (k = 0; k < 40 && ac_done[m] !== 1'b1; k++) @(negedge clk);
    chk({ac_done[m], ac_busy[m]}, 2'b10, "acyclic answer");
    chk(ac_err, ee, "acyclic error");
    if (!w && !ee) chk(ac_rdata, ed, "acyclic data");
  endtask

  initial begin
    int k;
    logic [1:0] got;
    {send, c1, c2, thr, cwr, crd, fault} = '0;
    {ac_start, ac_wr, ac_addr, ac_wdata} = '0;
    {mk1, mk2, p1, p2} = {8'hFF, 8'hFF, 8'h00, 8'h00};
    reset_n = 1'b0;
    void'($urandom(32'h82FF));
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    ac(0, 1'b0, 16'h0001, 8'h00, 8'hFF, 1'b0);
    ac(1, 1'b0, 16'h0002, 8'h00, 8'hFF, 1'b0);
    $display("test masks done");
    for (k = 0; k < 4; k++) begin
      @(posedge clk);
      fault <= (k == 2) ? 6'h00 : 6'($urandom);
      repeat (4) @(negedge clk);
      chk(m_diag, {32'h05810000, 2'h0, fault}, "diag");
    end
    ac(0, 1'b0, 16'h0003, 8'h00, {2'h0, fault}, 1'b0);
    ac(1, 1'b1, 16'h0003, 8'h3F, 8'h00, 1'b1);
    $display("test diagnosis done");
    frame(8'h01, 8'h00);
    frame(8'h01, 8'h00);
    frame(8'h3F, 8'h0F);
    frame(8'hCC, 8'h00);
    frame(8'h30, 8'h70);
    frame(8'h00, 8'h80);
    frame(8'h05, 8'h81);
    for (k = 0; k < 8; k++) frame(8'($urandom), 8'($urandom));
    $display("test frames done");
    ac(1, 1'b1, 16'h0001, 8'hFE, 8'h00, 1'b0);
    mk1 = 8'hFE;
    ac(0, 1'b0, 16'h0001, 8'h00, 8'hFE, 1'b0);
    frame(8'h00, 8'h00);
    frame(8'h01, 8'h00);
    frame(8'h00, 8'h02);
    $display("test mask gate done");
    ac(0, 1'b0, 16'h0105, 8'h00, 8'h5F, 1'b0);
    chk(cmd_q[24:8], {1'b0, 8'h01, 8'h05}, "forwarded read");
    ac(1, 1'b1, 16'h0207, 8'hA5, 8'h00, 1'b0);
    chk(cmd_q, {1'b1, 8'h02, 8'h07, 8'hA5}, "forwarded write");
    @(posedge clk);
    ac_start <= 2'b11;
    ac_wr <= 2'b00;
    ac_addr <= {16'h0002, 16'h0001};
    @(posedge clk);
    ac_start <= 2'b00;
    got = 2'b00;
    for (k = 0; k < 40; k++) begin
      @(negedge clk);
      got = got | ac_done;
    end
    chk(got, 2'b11, "both masters answered");
    $display("test acyclic done");
    close_out();
  end
endmodule
